/* include/tfp_pkg.sv */
// tfp_pkg: constants and carrier types of the t1 framer pin block.
// assumes a core clock far faster than every line or system clock.
package tfp_pkg;
  localparam int unsigned TFP_CLK_HZ    = 20000000;
  localparam int unsigned TFP_ADDR_W    = 4;
  localparam int unsigned TFP_DATA_W    = 32;
  localparam int unsigned TFP_NUM_CH    = 24;
  localparam int unsigned TFP_WORD_W    = 1;
  localparam int unsigned TFP_BUF_DEPTH = 2;
  localparam int unsigned TFP_CTRL_W    = 10;

  // register offsets
  localparam logic [3:0] TFP_OFS_CTRL   = 4'h0;
  localparam logic [3:0] TFP_OFS_BLOCK  = 4'h4;
  localparam logic [3:0] TFP_OFS_STATUS = 4'h8;
  localparam int unsigned TFP_ST_OVR_BIT = 24;

  // index of each pin in the input synchroniser vector
  localparam int unsigned TFP_SI_TXL = 0;
  localparam int unsigned TFP_SI_TXS = 1;
  localparam int unsigned TFP_SI_SER = 2;
  localparam int unsigned TFP_SI_SIG = 3;
  localparam int unsigned TFP_SI_LNK = 4;
  localparam int unsigned TFP_SI_TSS = 5;
  localparam int unsigned TFP_SI_TSY = 6;
  localparam int unsigned TFP_SI_RXL = 7;
  localparam int unsigned TFP_SI_RXS = 8;
  localparam int unsigned TFP_SI_RXD = 9;
  localparam int unsigned TFP_SI_RFS = 10;
  localparam int unsigned TFP_SI_N   = 11;

  // frame geometry
  localparam logic [2:0] TFP_BIT_LAST    = 3'h7;
  localparam logic [4:0] TFP_CH_LAST     = 5'h17;
  localparam logic [2:0] TFP_SIG_LAST    = 3'h5;
  localparam logic [4:0] TFP_MF_LAST_ESF = 5'h17;
  localparam logic [4:0] TFP_MF_LAST_D4  = 5'h0B;

  typedef struct packed {
    logic rx_es_enable;
    logic zbtsi_enable;
    logic format_esf;
    logic output_nrz_select;
    logic double_wide_sync_enable;
    logic sync_output_enable;
    logic sync_pulse_type_select;
    logic link_insert_enable;
    logic legacy_mode_select;
    logic tx_es_enable;
  } tfp_ctrl_t;

  typedef struct packed {
    logic       fbit;
    logic [4:0] ch;
    logic [2:0] bit_no;
    logic [4:0] frame;
    logic [2:0] sig;
  } tfp_tim_t;

  typedef logic [TFP_WORD_W-1:0] tfp_word_t;

  localparam tfp_ctrl_t          TFP_CTRL_RESET  = 10'h000;
  localparam tfp_tim_t           TFP_TIM_START   = 17'h10000;
  localparam logic [23:0]        TFP_BLOCK_RESET = 24'h000000;
endpackage

/* verilog/tfp_in_sync.sv */
// tfp_in_sync: two-flop synchronisers with edge detect for pin inputs.
// assumes every pin toggles slower than a third of the core clock rate.
`timescale 1ns/10ps
module tfp_in_sync #(
  parameter int unsigned N = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] pin,
  output logic [N-1:0]      level,
  output logic [N-1:0]      rise,
  output logic [N-1:0]      fall
);
  import tfp_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
  } tfp_sync_st_t;

  tfp_sync_st_t st;
  tfp_sync_st_t next_st;

  always_comb
  begin
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  // s1 feeds only s2; edges come from the settled stages
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      assign level[i] = st.s2[i];
      assign rise[i]  = st.s2[i] & ~st.s3[i];
      assign fall[i]  = ~st.s2[i] & st.s3[i];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

/* verilog/tfp_buf2.sv */
// tfp_buf2: two-entry valid/ready buffer between sampler and line output.
// assumes the consumer pops at most once per core clock.
`timescale 1ns/10ps
module tfp_buf2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import tfp_pkg::*;

  localparam logic [1:0] FULL = 2'(TFP_BUF_DEPTH);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } tfp_buf_st_t;

  tfp_buf_st_t st;
  tfp_buf_st_t next_st;
  logic        push;
  logic        pop;

  assign in_ready  = (st.cnt != FULL);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = ~st.wp;
    end
    if (pop)
      next_st.rp = ~st.rp;
    if (push && !pop)
      next_st.cnt = st.cnt + 2'h1;
    else if (pop && !push)
      next_st.cnt = st.cnt - 2'h1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

/* verilog/tfp_framer_pins.sv */
// tfp_framer_pins: serial pin timing of one t1 framer, tx and rx edges.
// assumes all line and system clocks arrive as pins sampled by clk.
// Overview of operation
// (RL1) tx path advances on transmit line clock
// (RL2) serial input sampled on falling reference edge
// (RL3) legacy mode channel clock high in lsb
// (RL4) channel block output per programmed channel mask
// (RL5) system clock supplied outside, used with store
// (RL6) link demand clock at frame/2 or frame/4
// (RL7) link data sampled on falling line edge
// (RL8) sync pin input aligns or output marks
// (RL9) double wide sync on signalling frames
// (RL10) system sync aligns timing only with store
// (RL11) signalling sampled and inserted when not legacy
// (RL12) rails updated on rising line clock edge
// (RL13) nrz select puts plain data on positive
// (RL14) rx link updated one bit before frame
// (RL15) rx link clock at frame/2 or frame/4
// (RL16) legacy mode rx channel clock high during lsb
// (RL17) framing bit first, then 24 channels
// (RL18) each channel msb first, lsb last
// (RL19) timing reference picked from store enable
`timescale 1ns/10ps
module tfp_framer_pins (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic [tfp_pkg::TFP_ADDR_W-1:0] reg_addr,
  input  wire logic [tfp_pkg::TFP_DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic [tfp_pkg::TFP_DATA_W-1:0]      reg_rdata,
  input  wire logic                           tx_line_clock,
  input  wire logic                           tx_system_clock,
  input  wire logic                           tx_serial_in,
  input  wire logic                           tx_signalling_in,
  input  wire logic                           tx_link_data,
  input  wire logic                           tx_system_sync,
  input  wire logic                           tx_frame_sync_i,
  output logic                                tx_frame_sync_o,
  output logic                                tx_frame_sync_oe,
  output logic                                tx_positive_rail,
  output logic                                tx_negative_rail,
  output logic                                tx_channel_clock,
  output logic                                tx_channel_block,
  output logic                                tx_link_demand_clock,
  input  wire logic                           rx_line_clock,
  input  wire logic                           rx_system_clock,
  input  wire logic                           rx_line_data,
  input  wire logic                           rx_frame_start,
  output logic                                rx_link_data,
  output logic                                rx_link_clock,
  output logic                                rx_channel_clock
);
  import tfp_pkg::*;

  typedef struct packed {
    tfp_ctrl_t             ctrl;
    logic [TFP_NUM_CH-1:0] block_mask;
    tfp_tim_t              tx_line;
    tfp_tim_t              tx_ref;
    tfp_tim_t              rx_line;
    tfp_tim_t              rx_sys;
    logic                  pend_valid;
    tfp_word_t             pend;
    logic                  mark_neg;
    logic                  link_bit;
    logic                  rx_link_hold;
    logic                  overrun;
    logic [TFP_DATA_W-1:0] rdata;
    logic                  tx_pos;
    logic                  tx_neg;
    logic                  tx_chclk;
    logic                  tx_chblk;
    logic                  tx_ldclk;
    logic                  sync_o;
    logic                  sync_oe;
    logic                  rx_link;
    logic                  rx_lclk;
    logic                  rx_chclk;
  } tfp_state_t;

  tfp_state_t          st;
  tfp_state_t          next_st;
  logic [TFP_SI_N-1:0] lvl;
  logic [TFP_SI_N-1:0] rise;
  logic [TFP_SI_N-1:0] fall;
  logic [4:0]          mf_last;
  tfp_tim_t            n_line;
  tfp_tim_t            n_rx;
  tfp_tim_t            rx_sel;
  logic                ref_fall;
  logic                mf_type;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic                buf_out_ready;
  tfp_word_t           buf_out_data;

  function automatic tfp_tim_t tim_step(tfp_tim_t t, logic [4:0] last);
    tfp_tim_t n;
    n = t;
    if (t.fbit)
    begin
      n.fbit   = 1'b0;
      n.ch     = 5'h00;
      n.bit_no = 3'h0;
    end
    else if (t.bit_no != TFP_BIT_LAST)
      n.bit_no = t.bit_no + 3'h1; // RL18
    else if (t.ch != TFP_CH_LAST)
    begin
      n.ch     = t.ch + 5'h01;
      n.bit_no = 3'h0;
    end
    else
    begin
      n.fbit  = 1'b1; // RL17
      n.frame = (t.frame >= last) ? 5'h00 : t.frame + 5'h01;
      n.sig   = (t.sig == TFP_SIG_LAST) ? 3'h0 : t.sig + 3'h1;
    end
    return n;
  endfunction

  // a frame-type pulse keeps the multiframe count running
  function automatic tfp_tim_t tim_align(tfp_tim_t t, logic keep_frame);
    tfp_tim_t n;
    n = TFP_TIM_START;
    if (keep_frame)
    begin
      n.frame = t.frame;
      n.sig   = t.sig;
    end
    return n;
  endfunction

  function automatic logic link_frame(tfp_tim_t t, logic zbtsi);
    return zbtsi ? (t.frame[1:0] == 2'h3) : t.frame[0];
  endfunction

  tfp_in_sync #(
    .N (TFP_SI_N)
  ) i_tfp_in_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   ({rx_frame_start, rx_line_data, rx_system_clock, rx_line_clock,
             tx_frame_sync_i, tx_system_sync, tx_link_data,
             tx_signalling_in, tx_serial_in, tx_system_clock,
             tx_line_clock}),
    .level (lvl),
    .rise  (rise),
    .fall  (fall)
  );

  tfp_buf2 #(
    .W (TFP_WORD_W)
  ) i_tfp_buf2 (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (st.pend_valid),
    .in_ready  (buf_in_ready),
    .in_data   (st.pend),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  assign mf_last = st.ctrl.format_esf ? TFP_MF_LAST_ESF : TFP_MF_LAST_D4;
  assign mf_type = st.ctrl.sync_pulse_type_select;
  assign n_line  = tim_step(st.tx_line, mf_last);
  assign n_rx    = tim_step(st.rx_line, mf_last);
  assign ref_fall = st.ctrl.tx_es_enable ? fall[TFP_SI_TXS] // RL2
                                         : fall[TFP_SI_TXL];
  assign rx_sel  = st.ctrl.rx_es_enable ? st.rx_sys : st.rx_line; // RL19
  // no pop in the framing slot; the sampler skips it too
  assign buf_out_ready = rise[TFP_SI_TXL] && !n_line.fbit; // RL1

  always_comb
  begin
    logic      bit_out;
    tfp_word_t smp;
    bit_out = 1'b0;
    smp     = '0;
    next_st = st;

    // register port
    next_st.rdata = '0;
    if (reg_write)
    begin
      case (reg_addr)
        TFP_OFS_CTRL:
          next_st.ctrl = tfp_ctrl_t'(reg_wdata[TFP_CTRL_W-1:0]);
        TFP_OFS_BLOCK:
          next_st.block_mask = reg_wdata[TFP_NUM_CH-1:0];
        TFP_OFS_STATUS:
          if (reg_wdata[TFP_ST_OVR_BIT])
            next_st.overrun = 1'b0;
        default:
          ;
      endcase
    end
    if (reg_read)
    begin
      case (reg_addr)
        TFP_OFS_CTRL:
          next_st.rdata = {22'h000000, st.ctrl};
        TFP_OFS_BLOCK:
          next_st.rdata = {8'h00, st.block_mask};
        TFP_OFS_STATUS:
          next_st.rdata = {7'h00, st.overrun, 3'h0, st.rx_line.frame,
                           3'h0, st.tx_line.ch, 3'h0, st.tx_line.frame};
        default:
          next_st.rdata = '0;
      endcase
    end

    // transmit line timing and rail outputs
    if (fall[TFP_SI_TXL] && !st.ctrl.sync_output_enable && lvl[TFP_SI_TSY])
      next_st.tx_line = tim_align(st.tx_line, !mf_type); // RL8
    else if (rise[TFP_SI_TXL])
    begin
      next_st.tx_line = n_line; // RL1
      if (n_line.fbit)
      begin
        // overhead pattern proper is the upstream formatter's job
        if (st.ctrl.link_insert_enable &&
            link_frame(n_line, st.ctrl.zbtsi_enable))
          bit_out = st.link_bit; // RL7
        else
          bit_out = n_line.frame[1] ^ n_line.frame[0];
      end
      else
        bit_out = buf_out_valid ? buf_out_data[0] : 1'b0;
      if (st.ctrl.output_nrz_select)
      begin
        next_st.tx_pos = bit_out; // RL13
        next_st.tx_neg = 1'b0;
      end
      else if (bit_out)
      begin
        next_st.tx_pos   = !st.mark_neg; // RL12
        next_st.tx_neg   = st.mark_neg;
        next_st.mark_neg = !st.mark_neg;
      end
      else
      begin
        next_st.tx_pos = 1'b0; // RL12
        next_st.tx_neg = 1'b0;
      end
      next_st.sync_o = n_line.fbit &&
                       (!mf_type || n_line.frame == 5'h00); // RL8
      if (!mf_type && st.ctrl.double_wide_sync_enable &&
          st.tx_line.fbit && n_line.sig == TFP_SIG_LAST)
        next_st.sync_o = 1'b1; // RL9
      next_st.tx_ldclk = st.ctrl.zbtsi_enable ? n_line.frame[1]
                                              : n_line.frame[0]; // RL6
    end
    next_st.sync_oe = st.ctrl.sync_output_enable; // RL8

    // captured link bit goes out in the next framing slot when that frame is a link frame
    if (fall[TFP_SI_TXL] && st.ctrl.link_insert_enable &&
        st.tx_line.ch == TFP_CH_LAST && st.tx_line.bit_no == TFP_BIT_LAST &&
        !st.tx_line.fbit)
      next_st.link_bit = lvl[TFP_SI_LNK]; // RL7

    // system side timing follows the line unless the store is on
    if (!st.ctrl.tx_es_enable)
      next_st.tx_ref = next_st.tx_line; // RL19
    else if (fall[TFP_SI_TXS] && lvl[TFP_SI_TSS])
      next_st.tx_ref = tim_align(st.tx_ref, !mf_type); // RL10
    else if (rise[TFP_SI_TXS])
      next_st.tx_ref = tim_step(st.tx_ref, mf_last); // RL5

    // sampler; a stalled buffer holds the word, a second sample is lost
    if (st.pend_valid && buf_in_ready)
      next_st.pend_valid = 1'b0;
    if (ref_fall && !st.tx_ref.fbit)
    begin
      smp[0] = lvl[TFP_SI_SER]; // RL2
      if (!st.ctrl.legacy_mode_select && st.tx_ref.sig == TFP_SIG_LAST &&
          st.tx_ref.bit_no == TFP_BIT_LAST)
        smp[0] = lvl[TFP_SI_SIG]; // RL11
      if (st.pend_valid && !buf_in_ready)
        next_st.overrun = 1'b1;
      else
      begin
        next_st.pend_valid = 1'b1;
        next_st.pend       = smp;
      end
    end

    next_st.tx_chclk = st.ctrl.legacy_mode_select && !st.tx_ref.fbit &&
                       st.tx_ref.bit_no == TFP_BIT_LAST; // RL3
    next_st.tx_chblk = !st.tx_ref.fbit && st.block_mask[st.tx_ref.ch]; // RL4

    // receive side
    if (fall[TFP_SI_RXL] && lvl[TFP_SI_RFS])
      next_st.rx_line = TFP_TIM_START;
    else if (rise[TFP_SI_RXL])
    begin
      next_st.rx_line = n_rx;
      if (!n_rx.fbit && n_rx.ch == TFP_CH_LAST &&
          n_rx.bit_no == TFP_BIT_LAST)
        next_st.rx_link = st.rx_link_hold; // RL14
      next_st.rx_lclk = st.ctrl.zbtsi_enable ? n_rx.frame[1]
                                             : n_rx.frame[0]; // RL15
    end
    if (fall[TFP_SI_RXL] && st.rx_line.fbit &&
        link_frame(st.rx_line, st.ctrl.zbtsi_enable))
      next_st.rx_link_hold = lvl[TFP_SI_RXD]; // RL14
    if (!st.ctrl.rx_es_enable)
      next_st.rx_sys = next_st.rx_line; // RL19
    else if (rise[TFP_SI_RXS])
      next_st.rx_sys = tim_step(st.rx_sys, mf_last);
    next_st.rx_chclk = st.ctrl.legacy_mode_select && !rx_sel.fbit &&
                       rx_sel.bit_no == TFP_BIT_LAST; // RL16
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st            <= '0;
      st.ctrl       <= TFP_CTRL_RESET;
      st.block_mask <= TFP_BLOCK_RESET;
      st.tx_line    <= TFP_TIM_START;
      st.tx_ref     <= TFP_TIM_START;
      st.rx_line    <= TFP_TIM_START;
      st.rx_sys     <= TFP_TIM_START;
    end
    else
      st <= next_st;
  end

  assign reg_rdata            = st.rdata;
  assign tx_frame_sync_o      = st.sync_o;
  assign tx_frame_sync_oe     = st.sync_oe;
  assign tx_positive_rail     = st.tx_pos;
  assign tx_negative_rail     = st.tx_neg;
  assign tx_channel_clock     = st.tx_chclk;
  assign tx_channel_block     = st.tx_chblk;
  assign tx_link_demand_clock = st.tx_ldclk;
  assign rx_link_data         = st.rx_link;
  assign rx_link_clock        = st.rx_lclk;
  assign rx_channel_clock     = st.rx_chclk;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_rails_on_rise: assert property ( // RL12
    ($changed(tx_positive_rail) || $changed(tx_negative_rail))
      |-> $past(rise[TFP_SI_TXL]))
    else $error("rail changed without a line clock rise");
  a_rails_exclusive: assert property ( // RL12
    !(tx_positive_rail && tx_negative_rail))
    else $error("both rails high");
  a_nrz_neg_quiet: assert property ( // RL13
    $rose(tx_negative_rail) |-> !$past(st.ctrl.output_nrz_select))
    else $error("negative rail marked in nrz mode");
  a_chclk_in_lsb: assert property ( // RL3
    $rose(tx_channel_clock) && $stable(st.ctrl) |->
      $past(st.tx_ref.bit_no) == TFP_BIT_LAST &&
      $past(st.ctrl.legacy_mode_select) ##1 tx_channel_clock)
    else $error("channel clock not in lsb");
  a_block_no_fbit: assert property ( // RL4
    $past(st.tx_ref.fbit) |-> !tx_channel_block)
    else $error("channel block high in framing slot");
  a_sync_on_fbit: assert property ( // RL8
    $rose(tx_frame_sync_o) && !st.ctrl.double_wide_sync_enable
      |-> st.tx_line.fbit)
    else $error("sync pulse off the framing bit");
  a_ref_mirror: assert property ( // RL19
    $past(!st.ctrl.tx_es_enable) |-> st.tx_ref == st.tx_line)
    else $error("reference timing left line timing");
  a_link_capture: assert property ( // RL7
    fall[TFP_SI_TXL] && st.ctrl.link_insert_enable && !st.tx_line.fbit &&
      st.tx_line.ch == TFP_CH_LAST && st.tx_line.bit_no == TFP_BIT_LAST
      |=> st.link_bit == $past(lvl[TFP_SI_LNK]))
    else $error("link bit not captured");
  a_rx_link_slot: assert property ( // RL14
    $changed(rx_link_data) |-> !st.rx_line.fbit &&
      st.rx_line.ch == TFP_CH_LAST && st.rx_line.bit_no == TFP_BIT_LAST)
    else $error("rx link updated off the last bit");
  a_read_one_cycle: assert property (
    !$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its cycle");

  c_chclk: cover property ($rose(tx_channel_clock));
  c_double_sync: cover property (
    tx_frame_sync_o && st.ctrl.double_wide_sync_enable && !st.tx_line.fbit);
  c_overrun: cover property ($rose(st.overrun));
  c_rx_link: cover property ($changed(rx_link_data));
endmodule

/* verification/tfp_line_model.sv */
// tfp_line_model: line interface and backplane side of the pin block.
// assumes the bench sets fill; pin clocks run free at the 400 ns rate.
`timescale 1ns/10ps
module tfp_line_model (
  input  wire logic fill,
  output logic      tx_line_clock,
  output logic      tx_system_clock,
  output logic      tx_serial_in,
  output logic      tx_signalling_in,
  output logic      tx_link_data,
  output logic      tx_system_sync,
  output logic      rx_line_clock,
  output logic      rx_system_clock,
  output logic      rx_line_data,
  output logic      rx_frame_start
);
  int unsigned sys_bit;
  int unsigned rx_bit;
  assign rx_system_clock = tx_system_clock;
  // odd offsets keep every pin clock out of phase with the core clock
  initial
  begin
    tx_line_clock = 1'b0;
    #13;
    forever #200 tx_line_clock = ~tx_line_clock;
  end
  initial
  begin
    tx_system_clock = 1'b0;
    #101;
    forever #200 tx_system_clock = ~tx_system_clock;
  end
  initial
  begin
    rx_line_clock = 1'b0;
    #37;
    forever #200 rx_line_clock = ~rx_line_clock;
  end
  initial
  begin
    {tx_serial_in, tx_signalling_in, tx_link_data} = 3'h0;
    {tx_system_sync, rx_line_data, rx_frame_start} = 3'h0;
    sys_bit = 0;
    rx_bit = 0;
  end
  // data moves on rising edges so it is steady at the sampling fall
  always @(posedge tx_line_clock)
  begin
    tx_serial_in <= fill;
    tx_signalling_in <= fill;
    tx_link_data <= ~tx_link_data;
  end
  always @(posedge tx_system_clock)
  begin
    sys_bit <= (sys_bit == 192) ? 0 : sys_bit + 1;
    tx_system_sync <= (sys_bit == 192);
  end
  // frame start marks each 12-frame multiframe; data flips every 2 frames
  always @(posedge rx_line_clock)
  begin
    rx_bit <= (rx_bit == 2315) ? 0 : rx_bit + 1;
    rx_frame_start <= (rx_bit == 2315);
    rx_line_data <= ((rx_bit / 386) % 2) != 0;
  end
endmodule

/* verification/tb_t1_framer_serial_pin_timing.sv */
// tb_t1_framer_serial_pin_timing: self-checking bench of the pin block.
// assumes one frame of 193 line bits spans exactly 1544 core clocks.
`timescale 1ns/10ps
module tb_t1_framer_serial_pin_timing;
  import tfp_pkg::*;
  localparam int unsigned FRAME_CLKS  = 1544;
  localparam int unsigned CYCLE_LIMIT = 75000;
  logic                  clk, rst_b, reg_write, reg_read, fill, meas;
  logic [TFP_ADDR_W-1:0] reg_addr;
  logic [TFP_DATA_W-1:0] reg_wdata, reg_rdata;
  logic                  txl, txs, ser, sig, lnk, tss, rxl, rxs, rxd, rfs;
  logic                  sync_o, sync_oe, sync_pin, pos, neg, cc, blk;
  logic                  ldc, rlk, rld, rcc, ldc_q, rlk_q, rld_q;
  logic [31:0]           cc_hi, rcc_hi, blk_hi, pos_hi, neg_hi, both_hi;
  logic [31:0]           sync_hi, oe_hi, ldc_tog, rlk_tog, rld_tog;
  int unsigned           failures, total_checks, cyc;
  // nothing else drives the sync pin: low unless the framer drives it
  assign sync_pin = sync_oe ? sync_o : 1'b0;
  tfp_framer_pins i_tfp_framer_pins (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tx_line_clock(txl), .tx_system_clock(txs), .tx_serial_in(ser),
    .tx_signalling_in(sig), .tx_link_data(lnk), .tx_system_sync(tss),
    .tx_frame_sync_i(sync_pin), .tx_frame_sync_o(sync_o),
    .tx_frame_sync_oe(sync_oe), .tx_positive_rail(pos),
    .tx_negative_rail(neg), .tx_channel_clock(cc), .tx_channel_block(blk),
    .tx_link_demand_clock(ldc), .rx_line_clock(rxl),
    .rx_system_clock(rxs), .rx_line_data(rxd), .rx_frame_start(rfs),
    .rx_link_data(rld), .rx_link_clock(rlk), .rx_channel_clock(rcc)
  );
  tfp_line_model i_tfp_line_model (
    .fill(fill), .tx_line_clock(txl), .tx_system_clock(txs),
    .tx_serial_in(ser), .tx_signalling_in(sig), .tx_link_data(lnk),
    .tx_system_sync(tss), .rx_line_clock(rxl), .rx_system_clock(rxs),
    .rx_line_data(rxd), .rx_frame_start(rfs)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // counters keep unknowns, so a floating output cannot pass
  always @(posedge clk)
  begin
    ldc_q <= ldc;
    rlk_q <= rlk;
    rld_q <= rld;
    cyc <= cyc + 1;
    if (meas)
    begin
      cc_hi <= cc_hi + cc;
      rcc_hi <= rcc_hi + rcc;
      blk_hi <= blk_hi + blk;
      pos_hi <= pos_hi + pos;
      neg_hi <= neg_hi + neg;
      both_hi <= both_hi + (pos & neg);
      sync_hi <= sync_hi + (sync_oe & sync_o);
      oe_hi <= oe_hi + sync_oe;
      ldc_tog <= ldc_tog + (ldc ^ ldc_q);
      rlk_tog <= rlk_tog + (rlk ^ rlk_q);
      rld_tog <= rld_tog + (rld ^ rld_q);
    end
    if (cyc == CYCLE_LIMIT)
    begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
    @(posedge clk);
  endtask
  task automatic set_ctrl(input tfp_ctrl_t c);
    wr(TFP_OFS_CTRL, {22'h000000, c});
  endtask
  // counts over whole frames, so the phase of the window does not matter
  // a frame of settling first lets any timing realignment pass
  task automatic window(input int unsigned n);
    repeat (FRAME_CLKS + 20) @(posedge clk);
    @(negedge clk);
    {cc_hi, rcc_hi, blk_hi, pos_hi, neg_hi, both_hi} = '0;
    {sync_hi, oe_hi, ldc_tog, rlk_tog, rld_tog} = '0;
    meas = 1'b1;
    repeat (n * FRAME_CLKS) @(posedge clk);
    @(negedge clk);
    meas = 1'b0;
    @(posedge clk);
  endtask
  task automatic test_regs();
    logic [31:0] v;
    rd(TFP_OFS_CTRL, v);
    chk("ctrl reset", v, 32'h00000000);
    rd(TFP_OFS_BLOCK, v);
    chk("block reset", v, 32'h00000000);
    wr(TFP_OFS_BLOCK, 32'hFFA5A5A5);
    rd(TFP_OFS_BLOCK, v);
    chk("block rw", v, 32'h00A5A5A5);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, v);
    chk("unmapped read", v, 32'h00000000);
    $display("test_regs done");
  endtask
  task automatic test_channel_clock();
    tfp_ctrl_t c;
    for (int i = 0; i < 3; i++)
    begin
      c = TFP_CTRL_RESET;
      c.legacy_mode_select = (i != 0);
      c.tx_es_enable = (i == 2);
      c.rx_es_enable = (i == 2);
      set_ctrl(c);
      window(1);
      chk("tx channel clock", cc_hi, (i != 0) ? 192 : 0);
      chk("rx channel clock", rcc_hi, (i != 0) ? 192 : 0);
    end
    $display("test_channel_clock done");
  endtask
  task automatic test_block();
    logic [23:0] m [4] = '{24'h000001, 24'h800000, 24'hFFFFFF, 24'h000000};
    int unsigned e [4] = '{64, 64, 1536, 0};
    set_ctrl(TFP_CTRL_RESET);
    for (int i = 0; i < 4; i++)
    begin
      wr(TFP_OFS_BLOCK, {8'h00, m[i]});
      window(1);
      chk("channel block", blk_hi, e[i]);
    end
    $display("test_block done");
  endtask
  task automatic test_link_clocks();
    tfp_ctrl_t c;
    c = TFP_CTRL_RESET;
    c.link_insert_enable = 1'b1;
    for (int z = 0; z < 2; z++)
    begin
      c.zbtsi_enable = z[0];
      set_ctrl(c);
      window(4);
      chk("tx link demand clock", ldc_tog, z ? 2 : 4);
      chk("rx link clock", rlk_tog, z ? 2 : 4);
      if (z == 0) chk("rx link data", rld_tog, 2);
    end
    $display("test_link_clocks done");
  endtask
  task automatic test_sync();
    tfp_ctrl_t c;
    c = TFP_CTRL_RESET;
    c.sync_output_enable = 1'b1;
    set_ctrl(c);
    window(1);
    chk("sync drive", oe_hi, FRAME_CLKS);
    chk("sync frame pulses", sync_hi, 8);
    c.double_wide_sync_enable = 1'b1;
    set_ctrl(c);
    window(6);
    chk("sync double wide", sync_hi, 56);
    $display("test_sync done");
  endtask
  task automatic test_rails();
    tfp_ctrl_t c;
    c = TFP_CTRL_RESET;
    c.output_nrz_select = 1'b1;
    set_ctrl(c);
    fill <= 1'b0;
    window(1);
    chk("sync released", oe_hi, 0);
    chk("nrz zeros", pos_hi <= 8, 1);
    chk("nrz negative", neg_hi, 0);
    fill <= 1'b1;
    window(1);
    chk("nrz ones", pos_hi >= 1536, 1);
    set_ctrl(TFP_CTRL_RESET);
    window(1);
    chk("ami marks", pos_hi + neg_hi >= 1536, 1);
    chk("ami overlap", both_hi, 0);
    chk("ami negative", neg_hi >= 760, 1);
    $display("test_rails done");
  endtask
  initial
  begin
    {rst_b, reg_write, reg_read, fill, meas, ldc_q, rlk_q, rld_q} = 8'h00;
    reg_addr = '0;
    reg_wdata = '0;
    {failures, total_checks, cyc} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    test_regs();
    test_channel_clock();
    test_block();
    test_link_clocks();
    test_sync();
    test_rails();
    complete_run();
  end
endmodule
